// file: mbac_pkg.sv
// Package for the mode based access checker: modes, targets, maps, carriers
package mbac_pkg;

	// CPU modes
	typedef enum logic [2:0] {
		MODE_BOOT,
		MODE_TEST,
		MODE_CLOS,
		MODE_SYS,
		MODE_USER
	} mbac_mode_t;

	// Memory targets as decoded by the address map in front of us
	typedef enum logic [2:0] {
		TGT_TROM,
		TGT_AROM,
		TGT_CLEEP,
		TGT_AEEP,
		TGT_CLRAM,
		TGT_ARAM,
		TGT_CPRAM,
		TGT_NONE
	} mbac_target_t;

	// SFR groups decoded from the register address
	typedef enum logic [2:0] {
		GRP_SEGCFG,
		GRP_SYSMGT,
		GRP_FWCFG,
		GRP_CLOSREG,
		GRP_TESTREG,
		GRP_HWCOMP,
		GRP_CPUGEN,
		GRP_NONE
	} mbac_group_t;

	// Memory request from the core or the coprocessor
	typedef struct packed {
		logic valid;
		logic rd;
		logic wr;
		logic ex;
		logic fromCoproc;
		mbac_target_t target;
		logic [15:0] addr;
		logic [2:0] segPerm;
	} mbac_memreq_t;

	// Mode sources: program_status_high and the two internal bits
	typedef struct packed {
		logic [7:0] programStatusHigh;
		logic [1:0] internalBits;
	} mbac_modesrc_t;

	// Segment permission bit positions (read, write, execute)
	localparam int SEG_R = 0;
	localparam int SEG_W = 1;
	localparam int SEG_X = 2;

	// Mode decode
	localparam logic [1:0] INT_BOOT = 2'h1;
	localparam logic [1:0] INT_TEST = 2'h2;
	localparam logic [1:0] INT_CLOS = 2'h3;
	localparam int PSH_SYS_BIT = 7;

	// Fixed memory areas
	localparam logic [15:0] ACM_BASE = 16'hff00;
	localparam logic [15:0] ACM_SIZE = 16'h0040;
	localparam logic [15:0] SROW_BASE = 16'h0000;
	localparam logic [15:0] SROW_SIZE = 16'h0080;

	// SFR addresses
	localparam logic [7:0] A_STP_LOW = 8'h80;
	localparam logic [7:0] A_STP_HIGH = 8'h81;
	localparam logic [7:0] A_SEG_END = 8'h83;
	localparam logic [7:0] A_PSH = 8'h84;
	localparam logic [7:0] A_PROT0 = 8'h85;
	localparam logic [7:0] A_PROT2 = 8'h87;
	localparam logic [7:0] A_SYS_END = 8'h8f;
	localparam logic [7:0] A_FWC_LOW = 8'h90;
	localparam logic [7:0] A_FWC_HIGH = 8'h91;
	localparam logic [7:0] A_XB_LOW = 8'h92;
	localparam logic [7:0] A_XB_HIGH = 8'h93;
	localparam logic [7:0] A_XS_LOW = 8'h94;
	localparam logic [7:0] A_XS_HIGH = 8'h95;
	localparam logic [7:0] A_FW_END = 8'h97;
	localparam logic [7:0] A_CLOS_END = 8'h9f;
	localparam logic [7:0] A_TEST_END = 8'ha7;
	localparam logic [7:0] A_HW_BASE = 8'hc0;
	localparam logic [7:0] A_CLK_SRC_SEL = 8'hc0;
	localparam logic [7:0] A_RANDOM = 8'hc1;
	localparam logic [7:0] A_KEY_A = 8'hc2;
	localparam logic [7:0] A_KEY_D = 8'hc3;
	localparam logic [7:0] A_HW_END = 8'hcf;
	localparam logic [7:0] A_CPU_BASE = 8'he0;

	// Reset values: all zero disables every segment and the exchange window
	localparam logic [7:0] RST_REG = 8'h00;

endpackage

// file: mode_based_access_checker.sv
// Mode based access checker for memory and special function registers
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - System mode: full rx app ROM, rwx app EEPROM, rw app RAM.
// - User mode: app ROM read/execute only per covering segment entry.
// - User mode: app EEPROM and app RAM access only per segment entry.
// - Contactless OS mode may read the 64-byte access matrix in ROM.
// - Contactless OS mode may access the exchange RAM window.
// - Boot or contactless OS mode may read EEPROM security rows.
// - Coprocessor reads EEPROM, reads and writes its own RAM.
// - Boot and test mode reach every register group except segment configuration.
// - Contactless OS: firewall regs read-only, own regs read/write.
// - Contactless OS hardware registers follow firewall control low/high.
// - System mode reaches segment, system, firewall and hardware groups.
// - User mode hardware registers follow the code segment's rights.
// - General CPU registers are open in every mode.
// - Program status high also readable in contactless OS and user.
// - Clock source select readable in contactless OS despite firewall.
// - Segment configuration registers denied outside system mode.
// - The three system protect registers are never readable.
// - Random number write-ignored; both key registers never readable.
// - System mode may rewrite the segment table pointer.
// - Segment table contents get no special protection.
// - Exchange RAM placement writable only by system, boot and test mode.
// - Denied reads return zero, denied writes are dropped.
// - Mode decoded into five modes from status high and internal bits.
// - Up to 64 segments; a segment without permissions is disabled.
// - Check completes before the physical location is reached.
module mode_based_access_checker (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire mbac_pkg::mbac_modesrc_t modeSrc,
	input wire mbac_pkg::mbac_memreq_t memReq,
	input wire logic [15:0] curSegSfrPerm,
	input wire logic [7:0] sfrAddr,
	input wire logic [7:0] sfrWrData,
	input wire logic sfrWr,
	input wire logic sfrRd,
	input wire logic [7:0] sfrExtRdData,
	output logic [7:0] sfrRdData,
	output logic sfrDenied,
	output logic sfrExtWrEn,
	output logic [7:0] sfrExtWrAddr,
	output logic [7:0] sfrExtWrData,
	output logic memGrant,
	output logic memDeny,
	output logic [15:0] segTablePtr,
	output logic [2:0] curMode
);

	mbac_pkg::mbac_mode_t mode;
	mbac_pkg::mbac_group_t grp;
	logic [7:0] stpLowQ, stpHighQ;
	logic [7:0] fwLowQ, fwHighQ;
	logic [7:0] xbLowQ, xbHighQ;
	logic [7:0] xsLowQ, xsHighQ;
	logic [15:0] fwMask, xBase, xSize, addrOff;
	logic inAcm, inSrow, inXram, memOk;
	logic rdOk, wrOk, hwBit, isInternal;
	logic [7:0] intRdData;
	logic [3:0] hwIdx;
	logic [16:0] srowDiff;

	// Five-way mode decode; internal bits override the status word
	always_comb begin
		unique case (modeSrc.internalBits)
			mbac_pkg::INT_BOOT: mode = mbac_pkg::MODE_BOOT;
			mbac_pkg::INT_TEST: mode = mbac_pkg::MODE_TEST;
			mbac_pkg::INT_CLOS: mode = mbac_pkg::MODE_CLOS;
			default: begin
				if (modeSrc.programStatusHigh[mbac_pkg::PSH_SYS_BIT]) begin
					mode = mbac_pkg::MODE_SYS;
				end else begin
					mode = mbac_pkg::MODE_USER;
				end
			end
		endcase
	end

	// Window helpers; offsets avoid overflow at the top of the map
	assign xBase = {xbHighQ, xbLowQ};
	assign xSize = {xsHighQ, xsLowQ};
	assign addrOff = memReq.addr - xBase;
	assign inXram = (memReq.addr >= xBase) && (addrOff < xSize);
	assign inAcm = (memReq.addr >= mbac_pkg::ACM_BASE) &&
		((memReq.addr - mbac_pkg::ACM_BASE) < mbac_pkg::ACM_SIZE);
	// Borrow bit instead of a compare that is always true for a zero base
	assign srowDiff = {1'b0, memReq.addr} - {1'b0, mbac_pkg::SROW_BASE};
	assign inSrow = !srowDiff[16] && (srowDiff[15:0] < mbac_pkg::SROW_SIZE);

	// Memory decision. The segment table address is not looked at: the
	// table is ordinary memory to this check, reached like any other.
	always_comb begin
		memOk = 1'b0;
		if (memReq.fromCoproc) begin
			unique case (memReq.target)
				mbac_pkg::TGT_CLEEP, mbac_pkg::TGT_AEEP:
					memOk = !memReq.wr && !memReq.ex;
				mbac_pkg::TGT_CPRAM:
					memOk = !memReq.ex;
				default: memOk = 1'b0;
			endcase
		end else begin
			unique case (mode)
				mbac_pkg::MODE_TEST: begin
					unique case (memReq.target)
						mbac_pkg::TGT_TROM, mbac_pkg::TGT_AROM:
							memOk = !memReq.wr;
						mbac_pkg::TGT_CLEEP, mbac_pkg::TGT_AEEP:
							memOk = 1'b1;
						mbac_pkg::TGT_CLRAM, mbac_pkg::TGT_ARAM:
							memOk = !memReq.ex;
						default: memOk = 1'b0;
					endcase
				end
				mbac_pkg::MODE_BOOT, mbac_pkg::MODE_CLOS: begin
					unique case (memReq.target)
						mbac_pkg::TGT_TROM: memOk = !memReq.wr;
						mbac_pkg::TGT_CLEEP: memOk = 1'b1;
						mbac_pkg::TGT_CLRAM: memOk = !memReq.ex;
						mbac_pkg::TGT_AROM:
							memOk = (mode == mbac_pkg::MODE_CLOS) && inAcm &&
								memReq.rd && !memReq.wr && !memReq.ex;
						mbac_pkg::TGT_AEEP:
							memOk = inSrow && memReq.rd &&
								!memReq.wr && !memReq.ex;
						mbac_pkg::TGT_ARAM:
							memOk = (mode == mbac_pkg::MODE_CLOS) && inXram &&
								!memReq.ex;
						default: memOk = 1'b0;
					endcase
				end
				mbac_pkg::MODE_SYS: begin
					unique case (memReq.target)
						mbac_pkg::TGT_AROM: memOk = !memReq.wr;
						mbac_pkg::TGT_AEEP: memOk = 1'b1;
						mbac_pkg::TGT_ARAM: memOk = !memReq.ex;
						default: memOk = 1'b0;
					endcase
				end
				mbac_pkg::MODE_USER: begin
					// A segment with no rights at all never matches anything
					memOk = (memReq.segPerm != 3'h0) &&
						(!memReq.rd || memReq.segPerm[mbac_pkg::SEG_R]) &&
						(!memReq.wr || memReq.segPerm[mbac_pkg::SEG_W]) &&
						(!memReq.ex || memReq.segPerm[mbac_pkg::SEG_X]);
					unique case (memReq.target)
						mbac_pkg::TGT_AROM:
							memOk = memOk && !memReq.wr;
						mbac_pkg::TGT_AEEP:
							memOk = memOk;
						mbac_pkg::TGT_ARAM:
							memOk = memOk && !memReq.ex;
						default: memOk = 1'b0;
					endcase
				end
			endcase
		end
	end

	// Decision is held one cycle; the core presents the physical access
	// only on the grant, so nothing denied ever touches the array.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			memGrant <= 1'b0;
			memDeny <= 1'b0;
		end else begin
			memGrant <= memReq.valid && memOk;
			memDeny <= memReq.valid && !memOk;
		end
	end

	// Register group decode
	always_comb begin
		if (sfrAddr >= mbac_pkg::A_CPU_BASE) begin
			grp = mbac_pkg::GRP_CPUGEN;
		end else if (sfrAddr >= mbac_pkg::A_HW_BASE &&
			sfrAddr <= mbac_pkg::A_HW_END) begin
			grp = mbac_pkg::GRP_HWCOMP;
		end else if (sfrAddr < mbac_pkg::A_STP_LOW) begin
			grp = mbac_pkg::GRP_NONE;
		end else if (sfrAddr <= mbac_pkg::A_SEG_END) begin
			grp = mbac_pkg::GRP_SEGCFG;
		end else if (sfrAddr <= mbac_pkg::A_SYS_END) begin
			grp = mbac_pkg::GRP_SYSMGT;
		end else if (sfrAddr <= mbac_pkg::A_FW_END) begin
			grp = mbac_pkg::GRP_FWCFG;
		end else if (sfrAddr <= mbac_pkg::A_CLOS_END) begin
			grp = mbac_pkg::GRP_CLOSREG;
		end else if (sfrAddr <= mbac_pkg::A_TEST_END) begin
			grp = mbac_pkg::GRP_TESTREG;
		end else begin
			grp = mbac_pkg::GRP_NONE;
		end
	end

	// Hardware register permission bit for firewall and segment masks
	assign hwIdx = sfrAddr[3:0];
	assign fwMask = {fwHighQ, fwLowQ};

	// Register decision: group access by mode, then fixed exceptions
	always_comb begin
		rdOk = 1'b0;
		wrOk = 1'b0;
		hwBit = 1'b0;
		unique case (mode)
			mbac_pkg::MODE_BOOT, mbac_pkg::MODE_TEST: begin
				rdOk = (grp != mbac_pkg::GRP_NONE);
				wrOk = (grp != mbac_pkg::GRP_NONE);
			end
			mbac_pkg::MODE_CLOS: begin
				hwBit = fwMask[hwIdx];
				unique case (grp)
					mbac_pkg::GRP_FWCFG: rdOk = 1'b1;
					mbac_pkg::GRP_CLOSREG: begin
						rdOk = 1'b1;
						wrOk = 1'b1;
					end
					mbac_pkg::GRP_HWCOMP: begin
						rdOk = hwBit ||
							(sfrAddr == mbac_pkg::A_CLK_SRC_SEL);
						wrOk = hwBit;
					end
					mbac_pkg::GRP_SYSMGT:
						rdOk = (sfrAddr == mbac_pkg::A_PSH);
					mbac_pkg::GRP_CPUGEN: begin
						rdOk = 1'b1;
						wrOk = 1'b1;
					end
					default: ;
				endcase
			end
			mbac_pkg::MODE_SYS: begin
				unique case (grp)
					mbac_pkg::GRP_SEGCFG, mbac_pkg::GRP_SYSMGT,
					mbac_pkg::GRP_FWCFG, mbac_pkg::GRP_HWCOMP,
					mbac_pkg::GRP_CPUGEN: begin
						rdOk = 1'b1;
						wrOk = 1'b1;
					end
					default: ;
				endcase
			end
			mbac_pkg::MODE_USER: begin
				hwBit = curSegSfrPerm[hwIdx];
				unique case (grp)
					mbac_pkg::GRP_HWCOMP: begin
						rdOk = hwBit;
						wrOk = hwBit;
					end
					mbac_pkg::GRP_SYSMGT:
						rdOk = (sfrAddr == mbac_pkg::A_PSH);
					mbac_pkg::GRP_CPUGEN: begin
						rdOk = 1'b1;
						wrOk = 1'b1;
					end
					default: ;
				endcase
			end
		endcase
		// Fixed denials, boot and test included; only system mode escapes the segment config one
		if (grp == mbac_pkg::GRP_SEGCFG && mode != mbac_pkg::MODE_SYS) begin
			rdOk = 1'b0;
			wrOk = 1'b0;
		end
		if (sfrAddr >= mbac_pkg::A_PROT0 && sfrAddr <= mbac_pkg::A_PROT2) begin
			rdOk = 1'b0;
		end
		if (sfrAddr == mbac_pkg::A_RANDOM) begin
			wrOk = 1'b0;
		end
		if (sfrAddr == mbac_pkg::A_KEY_A || sfrAddr == mbac_pkg::A_KEY_D) begin
			rdOk = 1'b0;
		end
	end

	// Registers held in this block
	assign isInternal = (grp == mbac_pkg::GRP_SEGCFG) ||
		(grp == mbac_pkg::GRP_FWCFG);

	always_comb begin
		unique case (sfrAddr)
			mbac_pkg::A_STP_LOW: intRdData = stpLowQ;
			mbac_pkg::A_STP_HIGH: intRdData = stpHighQ;
			mbac_pkg::A_FWC_LOW: intRdData = fwLowQ;
			mbac_pkg::A_FWC_HIGH: intRdData = fwHighQ;
			mbac_pkg::A_XB_LOW: intRdData = xbLowQ;
			mbac_pkg::A_XB_HIGH: intRdData = xbHighQ;
			mbac_pkg::A_XS_LOW: intRdData = xsLowQ;
			mbac_pkg::A_XS_HIGH: intRdData = xsHighQ;
			default: intRdData = 8'h00;
		endcase
	end

	// Segment table pointer; zero at reset leaves every segment unusable
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			stpLowQ <= mbac_pkg::RST_REG;
			stpHighQ <= mbac_pkg::RST_REG;
		end else if (sfrWr && wrOk) begin
			if (sfrAddr == mbac_pkg::A_STP_LOW) begin
				stpLowQ <= sfrWrData;
			end
			if (sfrAddr == mbac_pkg::A_STP_HIGH) begin
				stpHighQ <= sfrWrData;
			end
		end
	end

	// Firewall and exchange window; zero size keeps the window closed
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			fwLowQ <= mbac_pkg::RST_REG;
			fwHighQ <= mbac_pkg::RST_REG;
			xbLowQ <= mbac_pkg::RST_REG;
			xbHighQ <= mbac_pkg::RST_REG;
			xsLowQ <= mbac_pkg::RST_REG;
			xsHighQ <= mbac_pkg::RST_REG;
		end else if (sfrWr && wrOk) begin
			unique case (sfrAddr)
				mbac_pkg::A_FWC_LOW: fwLowQ <= sfrWrData;
				mbac_pkg::A_FWC_HIGH: fwHighQ <= sfrWrData;
				mbac_pkg::A_XB_LOW: xbLowQ <= sfrWrData;
				mbac_pkg::A_XB_HIGH: xbHighQ <= sfrWrData;
				mbac_pkg::A_XS_LOW: xsLowQ <= sfrWrData;
				mbac_pkg::A_XS_HIGH: xsHighQ <= sfrWrData;
				default: ;
			endcase
		end
	end

	// Read data one cycle after the strobe, zero when refused
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sfrRdData <= 8'h00;
		end else if (sfrRd && rdOk) begin
			sfrRdData <= isInternal ? intRdData : sfrExtRdData;
		end else begin
			sfrRdData <= 8'h00;
		end
	end

	// External writes forwarded only when allowed; refused ones vanish
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sfrExtWrEn <= 1'b0;
			sfrExtWrAddr <= 8'h00;
			sfrExtWrData <= 8'h00;
		end else begin
			sfrExtWrEn <= sfrWr && wrOk && !isInternal;
			sfrExtWrAddr <= sfrAddr;
			sfrExtWrData <= sfrWrData;
		end
	end

	// Refusal flag, a pulse one cycle after a denied strobe
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sfrDenied <= 1'b0;
		end else begin
			sfrDenied <= (sfrRd && !rdOk) || (sfrWr && !wrOk);
		end
	end

	// Status outputs for the address translation and for software
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			segTablePtr <= 16'h0000;
			curMode <= 3'h0;
		end else begin
			segTablePtr <= {stpHighQ, stpLowQ};
			curMode <= mode;
		end
	end

endmodule

`default_nettype wire

// file: mbac_properties.sv
// Port-level assertions for the mode based access checker
`timescale 1ns/100ps
`default_nettype none
module mbac_properties (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire mbac_pkg::mbac_modesrc_t modeSrc,
	input wire mbac_pkg::mbac_memreq_t memReq,
	input wire logic [15:0] curSegSfrPerm,
	input wire logic [7:0] sfrAddr,
	input wire logic [7:0] sfrWrData,
	input wire logic sfrWr,
	input wire logic sfrRd,
	input wire logic [7:0] sfrExtRdData,
	input wire logic [7:0] sfrRdData,
	input wire logic sfrDenied,
	input wire logic sfrExtWrEn,
	input wire logic [7:0] sfrExtWrAddr,
	input wire logic [7:0] sfrExtWrData,
	input wire logic memGrant,
	input wire logic memDeny,
	input wire logic [15:0] segTablePtr,
	input wire logic [2:0] curMode
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// Mode taken from the sources; the bench keeps it steady around requests
	logic inSys, inUser, inClos, anyAcc;
	assign inSys = modeSrc.internalBits == 2'h0 &&
		modeSrc.programStatusHigh[mbac_pkg::PSH_SYS_BIT];
	assign inUser = modeSrc.internalBits == 2'h0 &&
		!modeSrc.programStatusHigh[mbac_pkg::PSH_SYS_BIT];
	assign inClos = modeSrc.internalBits == mbac_pkg::INT_CLOS;
	assign anyAcc = sfrRd || sfrWr;
	sequence sMemAsk;
		memReq.valid;
	endsequence
	sequence sOneAnswer;
		memGrant ^ memDeny;
	endsequence
	AST_MEM_ONE_ANSWER: assert property (sMemAsk |=> sOneAnswer)
		else $error("memory request without exactly one answer");
	AST_MEM_QUIET: assert property (
		!memReq.valid |=> !memGrant && !memDeny)
		else $error("memory answer without a request");
	AST_RD_DENY_ZERO: assert property (
		sfrDenied && $past(sfrRd) |-> sfrRdData == 8'h00)
		else $error("denied read returned data");
	AST_SFR_QUIET: assert property (
		!anyAcc |=> !sfrDenied && !sfrExtWrEn && sfrRdData == 8'h00)
		else $error("register outputs active without a strobe");
	AST_SEGCFG_DENY: assert property (
		anyAcc && !inSys && sfrAddr inside {[8'h80:8'h83]} |=> sfrDenied)
		else $error("segment configuration reached outside system mode");
	AST_PROTECT_NO_READ: assert property (
		sfrRd && sfrAddr inside {[8'h85:8'h87]} |=>
		sfrDenied && sfrRdData == 8'h00)
		else $error("protect register was readable");
	AST_KEY_NO_READ: assert property (
		sfrRd && (sfrAddr == mbac_pkg::A_KEY_A ||
		sfrAddr == mbac_pkg::A_KEY_D) |=> sfrDenied)
		else $error("key register was readable");
	AST_RANDOM_NO_WRITE: assert property (
		sfrWr && sfrAddr == mbac_pkg::A_RANDOM |=> !sfrExtWrEn)
		else $error("random number register was written");
	AST_CPU_OPEN: assert property (
		anyAcc && sfrAddr >= mbac_pkg::A_CPU_BASE |=> !sfrDenied)
		else $error("general cpu register denied");
	AST_FW_READ_ONLY: assert property (
		inClos && sfrWr && sfrAddr inside {[8'h90:8'h97]} |=>
		sfrDenied && !sfrExtWrEn)
		else $error("firewall register written in contactless mode");
	AST_EXT_WRITE_PAIR: assert property (
		sfrExtWrEn |-> $past(sfrWr) && sfrExtWrAddr == $past(sfrAddr) &&
		sfrExtWrData == $past(sfrWrData))
		else $error("external write does not match its request");
	AST_USER_DISABLED_SEG: assert property (
		memReq.valid && inUser && !memReq.fromCoproc &&
		memReq.segPerm == 3'h0 |=> memDeny)
		else $error("disabled segment granted in user mode");
endmodule
`default_nettype wire

// file: mbac_sfr_model.sv
// Behavioural bank of the external registers behind the checker
`timescale 1ns/100ps
`default_nettype none
module mbac_sfr_model (
	input wire logic sys_clk,
	input wire logic [7:0] sfrAddr,
	input wire logic sfrExtWrEn,
	input wire logic [7:0] sfrExtWrAddr,
	input wire logic [7:0] sfrExtWrData,
	output logic [7:0] sfrExtRdData
);
	logic [7:0] bank [256];
	// Address-dependent fill so that a zeroed denied read stands out
	initial begin
		for (int i = 0; i < 256; i++) begin
			bank[i] = 8'(i) ^ 8'h5a;
		end
	end
	// Only writes the checker lets through ever land here
	always @(posedge sys_clk) begin
		if (sfrExtWrEn) begin
			bank[sfrExtWrAddr] <= sfrExtWrData;
		end
	end
	assign sfrExtRdData = bank[sfrAddr];
endmodule
`default_nettype wire

// file: mode_based_access_checker_tb_top.sv
// Self-checking testbench for the mode based access checker
`timescale 1ns/100ps
`default_nettype none
module mode_based_access_checker_tb_top;
	localparam logic [2:0] R = 3'h1;
	localparam logic [2:0] W = 3'h2;
	localparam logic [2:0] X = 3'h4;
	logic sys_clk, resetn, sfrWr, sfrRd;
	logic sfrDenied, sfrExtWrEn, memGrant, memDeny;
	mbac_pkg::mbac_modesrc_t modeSrc;
	mbac_pkg::mbac_memreq_t memReq;
	logic [15:0] curSegSfrPerm, segTablePtr;
	logic [7:0] sfrAddr, sfrWrData, sfrExtRdData, sfrRdData;
	logic [7:0] sfrExtWrAddr, sfrExtWrData;
	logic [2:0] curMode;
	int errors, checks_done;
	mode_based_access_checker mode_based_access_checker_inst (
		.sys_clk(sys_clk), .resetn(resetn), .modeSrc(modeSrc),
		.memReq(memReq),
		.curSegSfrPerm(curSegSfrPerm), .sfrAddr(sfrAddr), .sfrWrData(sfrWrData),
		.sfrWr(sfrWr), .sfrRd(sfrRd), .sfrExtRdData(sfrExtRdData),
		.sfrRdData(sfrRdData), .sfrDenied(sfrDenied), .sfrExtWrEn(sfrExtWrEn),
		.sfrExtWrAddr(sfrExtWrAddr), .sfrExtWrData(sfrExtWrData),
		.memGrant(memGrant), .memDeny(memDeny), .segTablePtr(segTablePtr),
		.curMode(curMode));
	mbac_sfr_model mbac_sfr_model_inst (.sys_clk(sys_clk), .sfrAddr(sfrAddr),
		.sfrExtWrEn(sfrExtWrEn), .sfrExtWrAddr(sfrExtWrAddr),
		.sfrExtWrData(sfrExtWrData), .sfrExtRdData(sfrExtRdData));
	// Free running 100 MHz clock
	always #5 sys_clk = ~sys_clk;
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Mode is given two edges to settle before anything relies on it
	task automatic setMode(input logic [1:0] ib, input logic [7:0] psh,
		input mbac_pkg::mbac_mode_t m);
		@(posedge sys_clk);
		modeSrc <= '{psh, ib};
		repeat (2) @(posedge sys_clk);
		#1;
		chk(16'(curMode), 16'(m));
	endtask
	// One-cycle read strobe; data and denial stand only in the next cycle
	task automatic sfrR(input logic [7:0] a, input logic [7:0] d, input logic den);
		@(posedge sys_clk);
		sfrAddr <= a;
		sfrRd <= 1'b1;
		@(posedge sys_clk);
		sfrRd <= 1'b0;
		#1;
		chk(16'({sfrDenied, sfrRdData}), 16'({den, d}));
	endtask
	// Allowed writes outside the segment and firewall groups go external
	task automatic sfrW(input logic [7:0] a, input logic [7:0] d, input logic den);
		logic ext;
		ext = !den && !(a inside {[8'h80:8'h83], [8'h90:8'h97]});
		@(posedge sys_clk);
		sfrAddr <= a;
		sfrWrData <= d;
		sfrWr <= 1'b1;
		@(posedge sys_clk);
		sfrWr <= 1'b0;
		#1;
		chk(16'({sfrDenied, sfrExtWrEn}), 16'({den, ext}));
		if (ext) chk({sfrExtWrAddr, sfrExtWrData}, {a, d});
	endtask
	task automatic memCase(input mbac_pkg::mbac_target_t t,
		input logic [2:0] op, input logic [15:0] a, input logic [2:0] sp,
		input logic cp, input logic g);
		@(posedge sys_clk);
		memReq <= '{1'b1, op[0], op[1], op[2], cp, t, a, sp};
		@(posedge sys_clk);
		memReq <= '0;
		#1;
		chk(16'({memDeny, memGrant}), 16'({!g, g}));
	endtask
	// Watchdog well beyond the roughly 140 cycles the tests need
	initial begin
		repeat (3000) @(posedge sys_clk);
		errors++;
		close_out();
	end
	initial begin
		sys_clk = 1'b0;
		resetn = 1'b0;
		modeSrc = '0;
		memReq = '0;
		curSegSfrPerm = 16'h0000;
		sfrAddr = 8'h00;
		sfrWrData = 8'h00;
		sfrWr = 1'b0;
		sfrRd = 1'b0;
		errors = 0;
		checks_done = 0;
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		#1;
		chk(16'({memGrant, memDeny, sfrDenied}), 16'h0000);
		chk(16'({sfrExtWrEn, sfrRdData}), 16'h0000);
		chk(segTablePtr, 16'h0000);
		setMode(2'h0, 8'h80, mbac_pkg::MODE_SYS);
		sfrR(8'h92, mbac_pkg::RST_REG, 1'b0);
		sfrW(8'h80, 8'h34, 1'b0);
		sfrW(8'h81, 8'h12, 1'b0);
		repeat (2) @(posedge sys_clk);
		#1;
		chk(segTablePtr, 16'h1234);
		sfrR(8'h80, 8'h34, 1'b0);
		sfrW(8'h90, 8'h20, 1'b0);
		sfrW(8'h93, 8'h10, 1'b0);
		sfrW(8'h94, 8'h10, 1'b0);
		sfrR(8'h85, 8'h00, 1'b1);
		sfrR(8'hc2, 8'h00, 1'b1);
		sfrW(8'hc1, 8'h99, 1'b1);
		sfrR(8'hc5, 8'hc5 ^ 8'h5a, 1'b0);
		memCase(mbac_pkg::TGT_AROM, R, 16'h0100, 3'h0, 1'b0, 1'b1);
		memCase(mbac_pkg::TGT_AROM, X, 16'h0100, 3'h0, 1'b0, 1'b1);
		memCase(mbac_pkg::TGT_AROM, W, 16'h0100, 3'h7, 1'b0, 1'b0);
		memCase(mbac_pkg::TGT_AEEP, W, 16'h0200, 3'h0, 1'b0, 1'b1);
		memCase(mbac_pkg::TGT_ARAM, W, 16'h0300, 3'h0, 1'b0, 1'b1);
		memCase(mbac_pkg::TGT_ARAM, X, 16'h0300, 3'h7, 1'b0, 1'b0);
		setMode(2'h0, 8'h00, mbac_pkg::MODE_USER);
		sfrW(8'h80, 8'hff, 1'b1);
		sfrR(8'h80, 8'h00, 1'b1);
		chk(segTablePtr, 16'h1234);
		sfrR(8'h84, 8'h84 ^ 8'h5a, 1'b0);
		sfrW(8'h84, 8'h00, 1'b1);
		@(posedge sys_clk);
		curSegSfrPerm <= 16'h0020;
		sfrR(8'hc5, 8'hc5 ^ 8'h5a, 1'b0);
		sfrR(8'hc6, 8'h00, 1'b1);
		sfrR(8'he0, 8'he0 ^ 8'h5a, 1'b0);
		memCase(mbac_pkg::TGT_AROM, R, 16'h0100, 3'h1, 1'b0, 1'b1);
		memCase(mbac_pkg::TGT_AROM, X, 16'h0100, 3'h1, 1'b0, 1'b0);
		memCase(mbac_pkg::TGT_AROM, W, 16'h0100, 3'h7, 1'b0, 1'b0);
		memCase(mbac_pkg::TGT_AEEP, W, 16'h0200, 3'h2, 1'b0, 1'b1);
		memCase(mbac_pkg::TGT_AEEP, R, 16'h0200, 3'h2, 1'b0, 1'b0);
		memCase(mbac_pkg::TGT_ARAM, R, 16'h0300, 3'h0, 1'b0, 1'b0);
		memCase(mbac_pkg::TGT_ARAM, W, 16'h1234, 3'h2, 1'b0, 1'b1);
		memCase(mbac_pkg::TGT_AEEP, R, 16'h0040, 3'h0, 1'b1, 1'b1);
		memCase(mbac_pkg::TGT_AEEP, W, 16'h0040, 3'h7, 1'b1, 1'b0);
		memCase(mbac_pkg::TGT_CPRAM, W, 16'h0010, 3'h0, 1'b1, 1'b1);
		memCase(mbac_pkg::TGT_ARAM, R, 16'h0300, 3'h7, 1'b1, 1'b0);
		setMode(mbac_pkg::INT_CLOS, 8'h00, mbac_pkg::MODE_CLOS);
		sfrR(8'h90, 8'h20, 1'b0);
		sfrW(8'h90, 8'hff, 1'b1);
		sfrW(8'h92, 8'h44, 1'b1);
		sfrW(8'h98, 8'h77, 1'b0);
		sfrR(8'h98, 8'h77, 1'b0);
		sfrR(8'hc5, 8'hc5 ^ 8'h5a, 1'b0);
		sfrR(8'hc6, 8'h00, 1'b1);
		sfrR(8'hc0, 8'hc0 ^ 8'h5a, 1'b0);
		sfrR(8'h84, 8'h84 ^ 8'h5a, 1'b0);
		sfrR(8'h81, 8'h00, 1'b1);
		memCase(mbac_pkg::TGT_AROM, R, 16'hff00, 3'h0, 1'b0, 1'b1);
		memCase(mbac_pkg::TGT_AROM, R, 16'hff3f, 3'h0, 1'b0, 1'b1);
		memCase(mbac_pkg::TGT_AROM, R, 16'hff40, 3'h0, 1'b0, 1'b0);
		memCase(mbac_pkg::TGT_ARAM, R, 16'h100f, 3'h0, 1'b0, 1'b1);
		memCase(mbac_pkg::TGT_ARAM, R, 16'h1010, 3'h0, 1'b0, 1'b0);
		memCase(mbac_pkg::TGT_ARAM, R, 16'h0fff, 3'h0, 1'b0, 1'b0);
		memCase(mbac_pkg::TGT_AEEP, R, 16'h007f, 3'h0, 1'b0, 1'b1);
		setMode(mbac_pkg::INT_BOOT, 8'h00, mbac_pkg::MODE_BOOT);
		sfrR(8'h90, 8'h20, 1'b0);
		sfrR(8'h98, 8'h77, 1'b0);
		sfrR(8'h80, 8'h00, 1'b1);
		memCase(mbac_pkg::TGT_AEEP, R, 16'h0000, 3'h0, 1'b0, 1'b1);
		memCase(mbac_pkg::TGT_AEEP, R, 16'h0080, 3'h0, 1'b0, 1'b0);
		setMode(mbac_pkg::INT_TEST, 8'h00, mbac_pkg::MODE_TEST);
		sfrR(8'ha0, 8'ha0 ^ 8'h5a, 1'b0);
		sfrR(8'h91, 8'h00, 1'b0);
		close_out();
	end
endmodule
bind mode_based_access_checker mbac_properties mbac_properties_inst (.sys_clk,
	.resetn, .modeSrc, .memReq, .curSegSfrPerm, .sfrAddr, .sfrWrData, .sfrWr,
	.sfrRd, .sfrExtRdData, .sfrRdData, .sfrDenied, .sfrExtWrEn, .sfrExtWrAddr,
	.sfrExtWrData, .memGrant, .memDeny, .segTablePtr, .curMode);
`default_nettype wire
